//--- shared/dxy_pkg.sv
// constants and types for the dual data space address generation block
// ==========================================================================
package dxy_pkg;
    // ======================================================================
    // widths and fixed constants
    localparam int unsigned ADDR_W       = 16;
    localparam int unsigned NUM_PTR      = 16;
    localparam int unsigned SEL_W        = 4;
    localparam logic [15:0] XY_BOUNDARY  = 16'h0800;
    localparam logic [3:0]  X_PF_A       = 4'h8;
    localparam logic [3:0]  X_PF_B       = 4'h9;
    localparam logic [3:0]  Y_PF_A       = 4'hA;
    localparam logic [3:0]  Y_PF_B       = 4'hB;
    localparam logic [15:0] PTR_RESET    = 16'h0000;
    localparam logic [15:0] ADDR_RESET   = 16'h0000;

    // addressing modes of the general (unified / x) operand
    typedef enum logic [2:0] {
        DXY_FILE_DIRECT = 3'h0,
        DXY_REG_DIRECT  = 3'h1,
        DXY_INDIRECT    = 3'h2,
        DXY_POST_MOD    = 3'h3,
        DXY_PRE_MOD     = 3'h4,
        DXY_INDEXED     = 3'h5,
        DXY_LIT_OFFSET  = 3'h6
    } dxy_mode_t;

    // prefetch modes of the multiply class operands
    typedef enum logic [2:0] {
        DXY_PF_NONE     = 3'h0,
        DXY_PF_INDIRECT = 3'h1,
        DXY_PF_POST2    = 3'h2,
        DXY_PF_POST4    = 3'h3,
        DXY_PF_POST6    = 3'h4,
        DXY_PF_INDEXED  = 3'h5
    } dxy_pf_mode_t;

    // one-hot unit state
    typedef enum logic [1:0] {
        DXY_ST_IDLE = 2'b01,
        DXY_ST_BUSY = 2'b10
    } dxy_state_t;
endpackage

//--- verilog/dxy_pf_unit.sv
// prefetch address generator for one data space (x or y)
`timescale 1ns/1ps
`default_nettype none
module dxy_pf_unit #(
    parameter logic [3:0] PTR_A = 4'h8,
    parameter logic [3:0] PTR_B = 4'h9
) (
    // request
    input  wire logic                  req,
    input  wire logic                  ptr_b_sel,
    input  wire dxy_pkg::dxy_pf_mode_t mode,
    input  wire logic                  step_neg,
    input  wire logic [15:0]           ptr_a_val,
    input  wire logic [15:0]           ptr_b_val,
    input  wire logic [15:0]           offset_val,
    input  wire logic                  mod_en,
    input  wire logic [15:0]           mod_start,
    input  wire logic [15:0]           mod_end,
    // result
    output logic                       rd_en,
    output logic [15:0]                addr,
    output logic                       wb_en,
    output logic [3:0]                 wb_sel,
    output logic [15:0]                wb_val,
    output logic                       illegal
);
    import dxy_pkg::*;
    logic [15:0] base;
    logic [15:0] step;
    logic [15:0] stepped;
    logic        is_post;

    assign base    = ptr_b_sel ? ptr_b_val : ptr_a_val;
    assign wb_sel  = ptr_b_sel ? PTR_B : PTR_A;
    assign is_post = (mode == DXY_PF_POST2) || (mode == DXY_PF_POST4) || (mode == DXY_PF_POST6);

    always_comb begin
        step = 16'h0000;
        case (mode)
            DXY_PF_POST2: step = 16'h0002;
            DXY_PF_POST4: step = 16'h0004;
            DXY_PF_POST6: step = 16'h0006;
            default:      step = 16'h0000;
        endcase
    end

    always_comb begin
        stepped = step_neg ? (base - step) : (base + step);
        // circular buffer wrap at either end of the window
        if (mod_en && !step_neg && base == mod_end) begin
            stepped = mod_start;
        end else if (mod_en && step_neg && base == mod_start) begin
            stepped = mod_end;
        end
    end

    // indexed only from the second pointer of the pair
    assign illegal = req && (mode == DXY_PF_INDEXED) && !ptr_b_sel;
    assign rd_en   = req && (mode != DXY_PF_NONE) && !illegal;
    assign addr    = (mode == DXY_PF_INDEXED) ? (base + offset_val) : base;
    assign wb_en   = rd_en && is_post;
    assign wb_val  = stepped;
endmodule
`default_nettype wire

//--- verilog/dxy_agu.sv
// dual data space address generation: unified/x unit plus x and y prefetch
`timescale 1ns/1ps
`default_nettype none
module dxy_agu (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // general operand request
    input  wire logic                  op_valid,
    input  wire logic                  op_write,
    input  wire dxy_pkg::dxy_mode_t    op_mode,
    input  wire logic [3:0]            op_base_sel,
    input  wire logic [3:0]            op_offset_sel,
    input  wire logic [15:0]           op_file_addr,
    input  wire logic [15:0]           op_literal,
    input  wire logic                  op_step_neg,
    input  wire logic [15:0]           op_step,
    input  wire logic                  op_bitrev_en,
    input  wire logic [15:0]           op_bitrev_mod,
    // modulo window of the general unit
    input  wire logic                  mod_en,
    input  wire logic [15:0]           mod_start,
    input  wire logic [15:0]           mod_end,
    // multiply class prefetch request
    input  wire logic                  pf_valid,
    input  wire logic                  pf_x_b_sel,
    input  wire dxy_pkg::dxy_pf_mode_t pf_x_mode,
    input  wire logic                  pf_x_neg,
    input  wire logic                  pf_y_b_sel,
    input  wire dxy_pkg::dxy_pf_mode_t pf_y_mode,
    input  wire logic                  pf_y_neg,
    input  wire logic                  ymod_en,
    input  wire logic [15:0]           ymod_start,
    input  wire logic [15:0]           ymod_end,
    // pointer file load from the execution pipeline
    input  wire logic                  ptr_load,
    input  wire logic [3:0]            ptr_load_sel,
    input  wire logic [15:0]           ptr_load_val,
    // x read bus
    output logic                       xrd_en,
    output logic [15:0]                xrd_addr,
    // x write bus (unified space)
    output logic                       wr_en,
    output logic [15:0]                wr_addr,
    // y read bus
    output logic                       yrd_en,
    output logic [15:0]                yrd_addr,
    // register direct operand and status
    output logic                       reg_direct,
    output logic [15:0]                reg_value,
    output logic                       in_y_space,
    output logic                       pf_illegal
);
    import dxy_pkg::*;

    // ======================================================================
    // pointer file
    logic [15:0] ptr_r [NUM_PTR];
    dxy_state_t  state_r;
    dxy_state_t  state_nxt;

    logic [15:0] base_v;
    logic [15:0] off_v;
    logic [15:0] step_v;
    logic [15:0] stepped;
    logic [15:0] ea;
    logic [15:0] ea_rev;
    logic        op_mem;
    logic        op_ptr_wb;

    // x prefetch unit signals
    logic        xp_rd;
    logic [15:0] xp_addr;
    logic        xp_wb;
    logic [3:0]  xp_sel;
    logic [15:0] xp_val;
    logic        xp_ill;
    // y prefetch unit signals
    logic        yp_rd;
    logic [15:0] yp_addr;
    logic        yp_wb;
    logic [3:0]  yp_sel;
    logic [15:0] yp_val;
    logic        yp_ill;

    // ======================================================================
    // general unit
    assign base_v = ptr_r[op_base_sel];
    assign off_v  = ptr_r[op_offset_sel];
    assign step_v = op_step;

    always_comb begin
        stepped = op_step_neg ? (base_v - step_v) : (base_v + step_v);
        if (mod_en && !op_step_neg && base_v == mod_end) begin
            stepped = mod_start;
        end else if (mod_en && op_step_neg && base_v == mod_start) begin
            stepped = mod_end;
        end
    end

    always_comb begin
        ea = base_v;
        case (op_mode)
            DXY_FILE_DIRECT: ea = op_file_addr;
            DXY_INDIRECT:    ea = base_v;
            DXY_POST_MOD:    ea = base_v;
            DXY_PRE_MOD:     ea = stepped;
            DXY_INDEXED:     ea = base_v + off_v;
            DXY_LIT_OFFSET:  ea = base_v + op_literal;
            default:         ea = base_v;
        endcase
    end

    // reverse-carry increment for bit-reversed buffers, x writes only
    always_comb begin
        ea_rev = base_v;
        for (int i = ADDR_W - 1; i >= 0; i--) begin
            if (op_bitrev_mod[i]) begin
                ea_rev[i] = ea_rev[i] ^ 1'b1;
                if (ea_rev[i]) begin
                    break;
                end
            end
        end
    end

    assign op_mem    = op_valid && (op_mode != DXY_REG_DIRECT);
    assign op_ptr_wb = op_valid && ((op_mode == DXY_POST_MOD) || (op_mode == DXY_PRE_MOD));

    // ======================================================================
    // prefetch units, fixed pointer routing
    dxy_pf_unit #(
        .PTR_A (X_PF_A),
        .PTR_B (X_PF_B)
    ) u_xpf (
        .req        (pf_valid),
        .ptr_b_sel  (pf_x_b_sel),
        .mode       (pf_x_mode),
        .step_neg   (pf_x_neg),
        .ptr_a_val  (ptr_r[X_PF_A]),
        .ptr_b_val  (ptr_r[X_PF_B]),
        .offset_val (ptr_r[4'hC]),
        .mod_en     (mod_en),
        .mod_start  (mod_start),
        .mod_end    (mod_end),
        .rd_en      (xp_rd),
        .addr       (xp_addr),
        .wb_en      (xp_wb),
        .wb_sel     (xp_sel),
        .wb_val     (xp_val),
        .illegal    (xp_ill)
    );

    dxy_pf_unit #(
        .PTR_A (Y_PF_A),
        .PTR_B (Y_PF_B)
    ) u_ypf (
        .req        (pf_valid),
        .ptr_b_sel  (pf_y_b_sel),
        .mode       (pf_y_mode),
        .step_neg   (pf_y_neg),
        .ptr_a_val  (ptr_r[Y_PF_A]),
        .ptr_b_val  (ptr_r[Y_PF_B]),
        .offset_val (ptr_r[4'hC]),
        .mod_en     (ymod_en),
        .mod_start  (ymod_start),
        .mod_end    (ymod_end),
        .rd_en      (yp_rd),
        .addr       (yp_addr),
        .wb_en      (yp_wb),
        .wb_sel     (yp_sel),
        .wb_val     (yp_val),
        .illegal    (yp_ill)
    );

    // ======================================================================
    // pointer updates; prefetch write-backs win over general write-back,
    // pipeline loads come first and win over both since they are the newest software intent
    genvar g;
    generate
        for (g = 0; g < NUM_PTR; g++) begin : g_ptr
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ptr_r[g] <= PTR_RESET;
                end else if (ptr_load && ptr_load_sel == 4'(g)) begin
                    ptr_r[g] <= ptr_load_val;
                end else if (xp_wb && xp_sel == 4'(g)) begin
                    ptr_r[g] <= xp_val;
                end else if (yp_wb && yp_sel == 4'(g)) begin
                    ptr_r[g] <= yp_val;
                end else if (op_ptr_wb && op_base_sel == 4'(g)) begin
                    if (op_write && op_bitrev_en && op_mode == DXY_POST_MOD) begin
                        ptr_r[g] <= ea_rev;
                    end else begin
                        ptr_r[g] <= stepped;
                    end
                end
            end
        end
    endgenerate

    // ======================================================================
    // state: busy the cycle after any request was valid
    always_comb begin
        case (state_r)
            DXY_ST_IDLE: state_nxt = (op_valid || pf_valid) ? DXY_ST_BUSY : DXY_ST_IDLE;
            DXY_ST_BUSY: state_nxt = (op_valid || pf_valid) ? DXY_ST_BUSY : DXY_ST_IDLE;
            default:     state_nxt = DXY_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= DXY_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ======================================================================
    // bus outputs, registered; x read bus shared by unified reads and prefetch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xrd_en   <= 1'b0;
            xrd_addr <= ADDR_RESET;
        end else if (op_mem && !op_write) begin
            xrd_en   <= 1'b1;
            xrd_addr <= ea;
        end else if (xp_rd) begin
            xrd_en   <= 1'b1;
            xrd_addr <= xp_addr;
        end else begin
            xrd_en   <= 1'b0;
            xrd_addr <= xrd_addr;
        end
    end

    // write address always unified; bit reversal never alters the effective
    // address of this access, only the pointer's next value
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_en   <= 1'b0;
            wr_addr <= ADDR_RESET;
        end else begin
            wr_en   <= op_mem && op_write;
            wr_addr <= (op_mem && op_write) ? ea : wr_addr;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            yrd_en   <= 1'b0;
            yrd_addr <= ADDR_RESET;
        end else begin
            yrd_en   <= yp_rd;
            yrd_addr <= yp_rd ? yp_addr : yrd_addr;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_direct <= 1'b0;
            reg_value  <= ADDR_RESET;
        end else begin
            reg_direct <= op_valid && (op_mode == DXY_REG_DIRECT);
            reg_value  <= base_v;
        end
    end

    // boundary is a package constant, nothing can write it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            in_y_space <= 1'b0;
            pf_illegal <= 1'b0;
        end else begin
            in_y_space <= op_mem && (ea >= XY_BOUNDARY);
            pf_illegal <= xp_ill || yp_ill;
        end
    end
endmodule
`default_nettype wire

//--- sim/dxy_agu_sva.sv
// checker: timing and address relations at the generator ports
`timescale 1ns/1ps
`default_nettype none
module dxy_agu_sva (
    // clock, reset and requests
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  op_valid,
    input wire logic                  op_write,
    input wire dxy_pkg::dxy_mode_t    op_mode,
    input wire logic [15:0]           op_file_addr,
    input wire logic                  pf_valid,
    input wire logic                  pf_x_b_sel,
    input wire dxy_pkg::dxy_pf_mode_t pf_x_mode,
    input wire logic                  pf_y_b_sel,
    input wire dxy_pkg::dxy_pf_mode_t pf_y_mode,
    // results
    input wire logic                  xrd_en,
    input wire logic [15:0]           xrd_addr,
    input wire logic                  wr_en,
    input wire logic                  yrd_en,
    input wire logic                  reg_direct,
    input wire logic                  in_y_space,
    input wire logic                  pf_illegal
);
    import dxy_pkg::*;
    // ======================================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_write_bus: assert property (op_valid && op_write && op_mode != DXY_REG_DIRECT |=> wr_en)
        else $error("write request gave no write strobe");
    a_read_xbus: assert property (op_valid && !op_write && op_mode != DXY_REG_DIRECT |=> xrd_en)
        else $error("read request gave no x read strobe");
    a_regdir_quiet: assert property (op_valid && op_mode == DXY_REG_DIRECT && !pf_valid
        |=> reg_direct && !xrd_en && !wr_en && !yrd_en) else $error("register direct hit the bus");
    a_file_addr: assert property (op_valid && !op_write && op_mode == DXY_FILE_DIRECT
        |=> xrd_addr == $past(op_file_addr)) else $error("direct address not passed through");
    a_y_space: assert property (op_valid && !op_write && op_mode == DXY_FILE_DIRECT
        |=> in_y_space == (xrd_addr >= XY_BOUNDARY)) else $error("space flag wrong");
    a_dual_read: assert property (pf_valid && !op_valid && pf_x_mode == DXY_PF_INDIRECT
        && pf_y_mode == DXY_PF_INDIRECT |=> xrd_en && yrd_en) else $error("reads not concurrent");
    a_x_idx_refused: assert property (pf_valid && pf_x_mode == DXY_PF_INDEXED && !pf_x_b_sel
        |=> pf_illegal) else $error("x indexed prefetch on wrong pointer accepted");
    a_y_idx_refused: assert property (pf_valid && pf_y_mode == DXY_PF_INDEXED && !pf_y_b_sel
        |=> pf_illegal && !yrd_en) else $error("y indexed prefetch on wrong pointer read");
    a_idle_quiet: assert property (!op_valid && !pf_valid |=> !xrd_en && !wr_en && !yrd_en)
        else $error("bus strobe without request");
endmodule
bind dxy_agu dxy_agu_sva u_sva (.clk, .rst, .op_valid, .op_write, .op_mode, .op_file_addr,
    .pf_valid, .pf_x_b_sel, .pf_x_mode, .pf_y_b_sel, .pf_y_mode, .xrd_en, .xrd_addr, .wr_en,
    .yrd_en, .reg_direct, .in_y_space, .pf_illegal);
`default_nettype wire

//--- sim/dxy_ram_model.sv
// data memory side model: counts cycles where both read paths fetch
`timescale 1ns/1ps
`default_nettype none
module dxy_ram_model (
    // read strobes
    input  wire logic clk,
    input  wire logic xrd_en,
    input  wire logic yrd_en,
    // count of dual fetch cycles
    output var int    n_dual
);
    // ======================================================================
    // dual port read tracking
    // one process owns the count, the port only mirrors it
    int count_r = 0;
    assign n_dual = count_r;
    always @(posedge clk) begin
        if (xrd_en === 1'b1 && yrd_en === 1'b1) count_r <= count_r + 1;
    end
endmodule
`default_nettype wire

//--- sim/dxy_agu_tb_top.sv
// self-checking bench for the dual data space address generator
`timescale 1ns/1ps
`default_nettype none
module dxy_agu_tb_top;
    import dxy_pkg::*;
    logic         clk, rst, op_valid, op_write, op_step_neg, op_bitrev_en, mod_en;
    logic         pf_valid, pf_x_b_sel, pf_x_neg, pf_y_b_sel, pf_y_neg, ymod_en, ptr_load;
    logic [3:0]   op_base_sel, op_offset_sel, ptr_load_sel;
    logic [15:0]  op_file_addr, op_literal, op_step, op_bitrev_mod, mod_start, mod_end;
    logic [15:0]  ymod_start, ymod_end, ptr_load_val, xrd_addr, wr_addr, yrd_addr, reg_value;
    logic         xrd_en, wr_en, yrd_en, reg_direct, in_y_space, pf_illegal;
    dxy_mode_t    op_mode;
    dxy_pf_mode_t pf_x_mode, pf_y_mode;
    int           num_errors = 0, n_checks = 0, n_dual;
    // ======================================================================
    // design and memory side
    dxy_agu u_dut (.clk, .rst, .op_valid, .op_write, .op_mode, .op_base_sel, .op_offset_sel,
        .op_file_addr, .op_literal, .op_step_neg, .op_step, .op_bitrev_en, .op_bitrev_mod,
        .mod_en, .mod_start, .mod_end, .pf_valid, .pf_x_b_sel, .pf_x_mode, .pf_x_neg,
        .pf_y_b_sel, .pf_y_mode, .pf_y_neg, .ymod_en, .ymod_start, .ymod_end, .ptr_load,
        .ptr_load_sel, .ptr_load_val, .xrd_en, .xrd_addr, .wr_en, .wr_addr, .yrd_en,
        .yrd_addr, .reg_direct, .reg_value, .in_y_space, .pf_illegal);
    dxy_ram_model u_ram (.clk, .xrd_en, .yrd_en, .n_dual);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ======================================================================
    // shared tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // load drops its strobe and lets an edge pass, so loads may follow each other
    task automatic ld(input logic [3:0] s, input logic [15:0] v);
        ptr_load_sel = s;
        ptr_load_val = v;
        ptr_load = 1'b1;
        @(negedge clk) ptr_load = 1'b0;
        @(negedge clk);
    endtask
    task automatic idle();
        op_valid = 1'b0;
        pf_valid = 1'b0;
        @(negedge clk);
    endtask
    // valid stays high on return so accesses run back to back
    task automatic acc(input dxy_mode_t m, input logic w, input logic [3:0] b,
                       input logic [15:0] ea);
        op_mode = m;
        op_write = w;
        op_base_sel = b;
        op_valid = 1'b1;
        @(negedge clk);
        chk(w ? "wr_addr" : "xrd_addr", w ? wr_addr : xrd_addr, ea);
        chk("strobe", 16'({xrd_en, wr_en}), w ? 16'h0001 : 16'h0002);
    endtask
    task automatic pf(input dxy_pf_mode_t xm, input dxy_pf_mode_t ym, input logic [15:0] xa,
                      input logic [15:0] ya);
        pf_x_mode = xm;
        pf_y_mode = ym;
        pf_valid = 1'b1;
        @(negedge clk);
        chk("xrd_addr", xrd_addr, xa);
        chk("yrd_addr", yrd_addr, ya);
        chk("dual strobe", 16'({xrd_en, yrd_en}), 16'h0003);
    endtask
    // ======================================================================
    // scenarios
    task automatic t_direct();
        ld(4'h1, 16'h0100);
        op_file_addr = 16'h0800;
        acc(DXY_FILE_DIRECT, 1'b0, 4'h0, 16'h0800);
        chk("in_y_space", 16'(in_y_space), 16'h0001);
        op_file_addr = 16'h07FE;
        acc(DXY_FILE_DIRECT, 1'b1, 4'h0, 16'h07FE);
        chk("in_y_space", 16'(in_y_space), 16'h0000);
        op_mode = DXY_REG_DIRECT;
        op_base_sel = 4'h1;
        @(negedge clk);
        chk("reg_value", reg_value, 16'h0100);
        chk("no access", 16'({reg_direct, xrd_en, wr_en}), 16'h0004);
        idle();
        $display("test direct done");
    endtask
    task automatic t_modify();
        acc(DXY_INDIRECT, 1'b0, 4'h1, 16'h0100);
        acc(DXY_INDIRECT, 1'b0, 4'h1, 16'h0100);
        op_step = 16'h0002;
        acc(DXY_POST_MOD, 1'b0, 4'h1, 16'h0100);
        acc(DXY_POST_MOD, 1'b0, 4'h1, 16'h0102);
        op_step_neg = 1'b1;
        op_step = 16'h0004;
        acc(DXY_PRE_MOD, 1'b1, 4'h1, 16'h0100);
        acc(DXY_PRE_MOD, 1'b1, 4'h1, 16'h00FC);
        idle();
        op_step_neg = 1'b0;
        op_step = 16'h0002;
        ld(4'h1, 16'hFFFE);
        acc(DXY_POST_MOD, 1'b1, 4'h1, 16'hFFFE);
        acc(DXY_INDIRECT, 1'b0, 4'h1, 16'h0000);
        idle();
        $display("test modify done");
    endtask
    task automatic t_index();
        ld(4'h2, 16'hFFF0);
        ld(4'h3, 16'h0020);
        op_offset_sel = 4'h3;
        acc(DXY_INDEXED, 1'b0, 4'h2, 16'h0010);
        acc(DXY_INDEXED, 1'b1, 4'h2, 16'h0010);
        op_literal = 16'hFFFE;
        acc(DXY_LIT_OFFSET, 1'b0, 4'h2, 16'hFFEE);
        acc(DXY_LIT_OFFSET, 1'b1, 4'h3, 16'h001E);
        idle();
        $display("test index done");
    endtask
    task automatic t_modulo();
        ld(4'h1, 16'h0104);
        mod_en = 1'b1;
        mod_start = 16'h0100;
        mod_end = 16'h0104;
        acc(DXY_POST_MOD, 1'b0, 4'h1, 16'h0104);
        acc(DXY_POST_MOD, 1'b0, 4'h1, 16'h0100);
        op_step_neg = 1'b1;
        acc(DXY_PRE_MOD, 1'b0, 4'h1, 16'h0100);
        acc(DXY_PRE_MOD, 1'b0, 4'h1, 16'h0104);
        idle();
        mod_en = 1'b0;
        op_step_neg = 1'b0;
        $display("test modulo done");
    endtask
    // reverse-carry stays enabled into the prefetch test: reads and y must ignore it
    task automatic t_bitrev();
        ld(4'h1, 16'h0200);
        op_bitrev_en = 1'b1;
        op_bitrev_mod = 16'h0008;
        acc(DXY_POST_MOD, 1'b0, 4'h1, 16'h0200);
        acc(DXY_POST_MOD, 1'b0, 4'h1, 16'h0202);
        acc(DXY_POST_MOD, 1'b1, 4'h1, 16'h0204);
        // the write's pointer update took the reverse-carry step
        acc(DXY_INDIRECT, 1'b0, 4'h1, 16'h020C);
        idle();
        $display("test bitrev done");
    endtask
    task automatic t_prefetch();
        ld(4'h8, 16'h0010);
        ld(4'h9, 16'h0020);
        ld(4'hA, 16'h0900);
        ld(4'hB, 16'h0A00);
        ld(4'hC, 16'h0006);
        pf(DXY_PF_POST4, DXY_PF_INDIRECT, 16'h0010, 16'h0900);
        pf(DXY_PF_INDIRECT, DXY_PF_POST2, 16'h0014, 16'h0900);
        pf(DXY_PF_POST6, DXY_PF_POST6, 16'h0014, 16'h0902);
        pf(DXY_PF_INDIRECT, DXY_PF_INDIRECT, 16'h001A, 16'h0908);
        pf_x_b_sel = 1'b1;
        pf_y_b_sel = 1'b1;
        pf(DXY_PF_INDEXED, DXY_PF_INDEXED, 16'h0026, 16'h0A06);
        idle();
        chk("dual count", n_dual[15:0], 16'h0005);
        pf_x_b_sel = 1'b0;
        pf_y_b_sel = 1'b0;
        // y circular window, both step directions
        ymod_en = 1'b1;
        ymod_start = 16'h0900;
        ymod_end = 16'h0908;
        pf(DXY_PF_INDIRECT, DXY_PF_POST2, 16'h001A, 16'h0908);
        pf_x_neg = 1'b1;
        pf_y_neg = 1'b1;
        pf(DXY_PF_POST4, DXY_PF_POST2, 16'h001A, 16'h0900);
        pf(DXY_PF_INDIRECT, DXY_PF_INDIRECT, 16'h0016, 16'h0908);
        idle();
        pf_x_mode = DXY_PF_INDEXED;
        pf_y_mode = DXY_PF_INDEXED;
        pf_valid = 1'b1;
        @(negedge clk) pf_valid = 1'b0;
        chk("refused", 16'({pf_illegal, xrd_en, yrd_en}), 16'h0004);
        $display("test prefetch done");
    endtask
    // ======================================================================
    // main sequence and watchdog
    initial begin
        {rst, op_valid, op_write, op_step_neg, op_bitrev_en, mod_en, pf_valid} = 7'h40;
        {pf_x_b_sel, pf_x_neg, pf_y_b_sel, pf_y_neg, ymod_en, ptr_load} = 6'h00;
        {op_base_sel, op_offset_sel, ptr_load_sel} = 12'h000;
        {op_file_addr, op_literal, op_step, op_bitrev_mod, mod_start, mod_end} = 96'h0;
        {ymod_start, ymod_end, ptr_load_val} = 48'h0;
        op_mode = DXY_FILE_DIRECT;
        pf_x_mode = DXY_PF_NONE;
        pf_y_mode = DXY_PF_NONE;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("idle outputs", 16'({xrd_en, wr_en, yrd_en, reg_direct, pf_illegal}), 16'h0000);
        t_direct();
        t_modify();
        t_index();
        t_modulo();
        t_bitrev();
        t_prefetch();
        complete_run();
    end
    initial begin
        repeat (4000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
